/* core/rio_assign_cfg.svh */
// Offsets, function codes and reset defaults of the remote I/O assignment block
`ifndef RIO_ASSIGN_CFG_SVH
`define RIO_ASSIGN_CFG_SVH

// Register byte offsets
`define RIO_OFS_OUT_CODE 8'h00
`define RIO_OFS_IN_CODE 8'h40
`define RIO_OFS_DIR_CODE 8'h80
`define RIO_OFS_MODE 8'ha0
`define RIO_OFS_REMOTE_IN 8'ha4
`define RIO_OFS_REMOTE_OUT 8'ha8
`define RIO_MODE_RST 1'b0
`define RIO_MODE_3WIRE_BIT 0

// Input function codes
`define RIO_FN_UNUSED 8'h00
`define RIO_FN_ALARM_CLEAR 8'h08
`define RIO_FN_NOTICE_CLEAR 8'h0e
`define RIO_FN_TOOL_LOCK 8'h10
`define RIO_FN_TORQUE_CAP 8'h16
`define RIO_FN_OUTSIDE_FAULT 8'h19
`define RIO_FN_RUN_FORWARD 8'h3a
`define RIO_FN_RUN_BACKWARD 8'h3b
`define RIO_FN_DSEL0 8'h40
`define RIO_FN_DSEL1 8'h41
`define RIO_FN_DSEL2 8'h42
`define RIO_FN_STOP_MODE 8'h48

// Status function codes
`define RIO_FN_ALARM_OUT 8'h81
`define RIO_FN_MOVING 8'h86
`define RIO_FN_NOTICE 8'h87
`define RIO_FN_BUSY 8'h88
`define RIO_FN_TORQ_LIMITED 8'h8c
`define RIO_FN_SPEED_REACHED 8'h8d
`define RIO_FN_TURN_SENSE 8'h94
`define RIO_FN_MAIN_SUPPLY 8'ha8

// Output slot reset codes, slot 15 first
`define RIO_OUT_DEFAULTS {`RIO_FN_TORQ_LIMITED, `RIO_FN_SPEED_REACHED, `RIO_FN_MOVING, \
	`RIO_FN_UNUSED, `RIO_FN_UNUSED, `RIO_FN_MAIN_SUPPLY, `RIO_FN_TURN_SENSE, `RIO_FN_BUSY, \
	`RIO_FN_ALARM_OUT, `RIO_FN_NOTICE, `RIO_FN_STOP_MODE, `RIO_FN_RUN_BACKWARD, \
	`RIO_FN_RUN_FORWARD, `RIO_FN_DSEL2, `RIO_FN_DSEL1, `RIO_FN_DSEL0}

// Input slot reset codes, slot 15 first
`define RIO_IN_DEFAULTS {{8{`RIO_FN_UNUSED}}, `RIO_FN_ALARM_CLEAR, `RIO_FN_UNUSED, \
	`RIO_FN_STOP_MODE, `RIO_FN_RUN_BACKWARD, `RIO_FN_RUN_FORWARD, `RIO_FN_DSEL2, \
	`RIO_FN_DSEL1, `RIO_FN_DSEL0}

`endif

/* core/rio_assign_pkg.sv */
// Types shared by the remote I/O assignment block
package rio_assign_pkg;
	typedef logic [7:0] rio_code_t;
	typedef enum {RIO_IDLE, RIO_FETCH, RIO_DONE} rio_apb_t;
endpackage

/* core/rio_code_mem.sv */
// Function code store with parallel taps and a registered read port
`timescale 1ns/1ps
module rio_code_mem
	import rio_assign_pkg::*;
#(
	parameter int DEPTH = 37,
	parameter int AW = 6,
	parameter logic [DEPTH*8-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire rio_code_t wdata,
	input wire logic [AW-1:0] raddr,
	output rio_code_t rdata,
	output logic [DEPTH*8-1:0] codes
);

	////////////////////////////////////////////////////////////////////////////
	// One entry per slot, reset to its default code
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_ent
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					codes[i*8 +: 8] <= INIT[i*8 +: 8];
				else if (we && waddr == AW'(i))
					codes[i*8 +: 8] <= wdata;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Read data registered; out of range reads as zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (int'(raddr) < DEPTH)
			rdata <= codes[int'(raddr)*8 +: 8];
		else
			rdata <= 8'h00;
	end

endmodule // rio_code_mem

/* core/rio_signal_assign.sv */
// Remote I/O signal assignment: slot codes, input decode and output select
//
// Behaviour
// - Sixteen output slot codes; slots 0-2 reset to data-select echoes 64-66
// - Slots 3, 4, 5 reset to echo codes 58, 59, 72
// - Slots 6, 7, 8 reset to notice 135, alarm 129, busy 136
// - Slots 9, 10, 13 reset to turn sense 148, supply 168, moving 134
// - Slots 14, 15 reset to 141, 140; slots 11, 12 reset to zero
// - 3-wire mode reinterprets codes 59 and 72; their echoes are unchanged
// - Input slot with code zero drives no function
// - Alarm clear fires once on off-to-on of code 8
// - Notice clear fires on off-to-on of code 14
// - Code 16 on releases tool lock; off keeps it
// - Code 22 on enables torque limiting; off disables it
// - Code 25 turning off raises outside stop alarm and forces stop
// - Code 58 on runs the motor; off stops it
// - Code 59 is reverse run normally, go/brake in 3-wire mode
// - Codes 64, 65, 66 form the binary data number
// - Unassigned codes 16 and 22 read as permanently on
// - Code 25 refused on remote inputs; unassigned reads as on
// - Code 72 selects instant stop normally, forward direction in 3-wire
// - Several terminals OR together, but codes 16 and 22 AND
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "rio_assign_cfg.svh"
module rio_signal_assign
	import rio_assign_pkg::*;
#(
	parameter int NUM_DIR = 5
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [NUM_DIR-1:0] DIRECT_IN,
	input wire logic ALARM_OUTPUT,
	input wire logic NOTICE_FLAG,
	input wire logic SYSTEM_BUSY_FLAG,
	input wire logic TURN_SENSE_FLAG,
	input wire logic MAIN_SUPPLY_FLAG,
	input wire logic MOTOR_MOVING_FLAG,
	input wire logic SPEED_REACHED_FLAG,
	input wire logic TORQUE_LIMITED_FLAG,
	output logic [15:0] REMOTE_OUT,
	output logic ALARM_CLEAR,
	output logic NOTICE_CLEAR,
	output logic TOOL_LOCK_RELEASE,
	output logic TORQUE_CAP_ENABLE,
	output logic EXT_STOP_ALARM,
	output logic MOTOR_FORCE_STOP,
	output logic MOTOR_RUN,
	output logic RUN_BACKWARD,
	output logic GO_BRAKE,
	output logic STOP_INSTANT,
	output logic DIR_FORWARD,
	output logic [2:0] DATA_SELECT
);

	localparam int DEPTH = 32 + NUM_DIR;
	localparam logic [DEPTH*8-1:0] INIT = {{(NUM_DIR*8){1'b0}}, `RIO_IN_DEFAULTS,
		`RIO_OUT_DEFAULTS};

	rio_apb_t stage_r;
	rio_code_t mem_rdata;
	logic [DEPTH*8-1:0] codes;
	logic [5:0] idx;
	logic wr_done, addr_mem, mem_we, refuse, mode_r;
	logic [15:0] remote_in_r;
	logic [NUM_DIR-1:0] din_meta_r, din_r;
	logic st_aclr, st_nclr, st_tool, st_tcap, st_fault, st_run, st_back, st_stop;
	logic [2:0] st_dsel;
	logic prev_aclr_r, prev_nclr_r, prev_fault_r;
	logic [15:0] rout_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign idx = PADDR[7:2];
	assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
	assign addr_mem = (PADDR[11:8] == 4'h0) && (int'(idx) < DEPTH);
	// Outside fault may not sit on a remote input slot
	assign refuse = addr_mem && (idx[5:4] == 2'b01) &&
		(PWDATA[7:0] == `RIO_FN_OUTSIDE_FAULT);
	assign mem_we = wr_done && addr_mem && !refuse;

	rio_code_mem #(.DEPTH(DEPTH), .AW(6), .INIT(INIT)) u_codes (
		.clk(MCLK),
		.rst(RST),
		.we(mem_we),
		.waddr(idx),
		.wdata(PWDATA[7:0]),
		.raddr(idx),
		.rdata(mem_rdata),
		.codes(codes)
	);

	// Two-cycle access phase: code store read is registered
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			stage_r <= RIO_IDLE;
			PREADY <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end else begin
			case (stage_r)
				RIO_IDLE: begin
					PREADY <= 1'b0;
					if (PSEL && !PENABLE)
						stage_r <= RIO_FETCH;
				end
				RIO_FETCH: begin
					PREADY <= 1'b1;
					stage_r <= RIO_DONE;
					PSLVERR <= 1'b0;
					PRDATA <= 32'h0;
					if (addr_mem) begin
						PRDATA <= {24'h0, mem_rdata};
						PSLVERR <= PWRITE && refuse;
					end else if (PADDR == {4'h0, `RIO_OFS_MODE})
						PRDATA <= {31'h0, mode_r};
					else if (PADDR == {4'h0, `RIO_OFS_REMOTE_IN})
						PRDATA <= {16'h0, remote_in_r};
					else if (PADDR == {4'h0, `RIO_OFS_REMOTE_OUT})
						PRDATA <= {16'h0, REMOTE_OUT};
					else
						PSLVERR <= 1'b1;
				end
				RIO_DONE: begin
					PREADY <= 1'b0;
					PSLVERR <= 1'b0;
					stage_r <= RIO_IDLE;
				end
				default: stage_r <= RIO_IDLE;
			endcase
		end
	end

	// Mode and remote input word written by the host
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			mode_r <= `RIO_MODE_RST;
			remote_in_r <= 16'h0;
		end else if (wr_done) begin
			if (PADDR == {4'h0, `RIO_OFS_MODE})
				mode_r <= PWDATA[`RIO_MODE_3WIRE_BIT];
			if (PADDR == {4'h0, `RIO_OFS_REMOTE_IN})
				remote_in_r <= PWDATA[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Direct pins come from outside the clock domain
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			din_meta_r <= '0;
			din_r <= '0;
		end else begin
			din_meta_r <= DIRECT_IN;
			din_r <= din_meta_r;
		end
	end

	// Returns {assigned, any terminal on, all terminals on}
	function automatic logic [2:0] fn_eval(input rio_code_t c);
		logic asg, any_on, all_on;
		asg = 1'b0;
		any_on = 1'b0;
		all_on = 1'b1;
		for (int t = 0; t < 16 + NUM_DIR; t++) begin
			logic hit, lvl;
			if (t < 16) begin
				hit = (codes[(16 + t)*8 +: 8] == c) && (c != `RIO_FN_OUTSIDE_FAULT);
				lvl = remote_in_r[t];
			end else begin
				hit = (codes[(16 + t)*8 +: 8] == c);
				lvl = din_r[t - 16];
			end
			if (hit && c != `RIO_FN_UNUSED) begin
				asg = 1'b1;
				any_on = any_on | lvl;
				all_on = all_on & lvl;
			end
		end
		return {asg, any_on, all_on};
	endfunction

	// Function states; lock and cap AND and default on, others OR
	always_comb begin
		logic [2:0] e;
		e = fn_eval(`RIO_FN_TOOL_LOCK);
		st_tool = e[2] ? e[0] : 1'b1;
		e = fn_eval(`RIO_FN_TORQUE_CAP);
		st_tcap = e[2] ? e[0] : 1'b1;
		e = fn_eval(`RIO_FN_OUTSIDE_FAULT);
		st_fault = e[2] ? e[1] : 1'b1;
		e = fn_eval(`RIO_FN_ALARM_CLEAR);
		st_aclr = e[1];
		e = fn_eval(`RIO_FN_NOTICE_CLEAR);
		st_nclr = e[1];
		e = fn_eval(`RIO_FN_RUN_FORWARD);
		st_run = e[1];
		e = fn_eval(`RIO_FN_RUN_BACKWARD);
		st_back = e[1];
		e = fn_eval(`RIO_FN_STOP_MODE);
		st_stop = e[1];
		e = fn_eval(`RIO_FN_DSEL0);
		st_dsel[0] = e[1];
		e = fn_eval(`RIO_FN_DSEL1);
		st_dsel[1] = e[1];
		e = fn_eval(`RIO_FN_DSEL2);
		st_dsel[2] = e[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge events; fault history resets on so reset raises no alarm
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			prev_aclr_r <= 1'b0;
			prev_nclr_r <= 1'b0;
			prev_fault_r <= 1'b1;
			ALARM_CLEAR <= 1'b0;
			NOTICE_CLEAR <= 1'b0;
			EXT_STOP_ALARM <= 1'b0;
		end else begin
			prev_aclr_r <= st_aclr;
			prev_nclr_r <= st_nclr;
			prev_fault_r <= st_fault;
			ALARM_CLEAR <= st_aclr && !prev_aclr_r;
			NOTICE_CLEAR <= st_nclr && !prev_nclr_r;
			EXT_STOP_ALARM <= !st_fault && prev_fault_r;
		end
	end

	// Level functions, mode selects the meaning of 59 and 72
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			TOOL_LOCK_RELEASE <= 1'b1;
			TORQUE_CAP_ENABLE <= 1'b1;
			MOTOR_FORCE_STOP <= 1'b0;
			MOTOR_RUN <= 1'b0;
			RUN_BACKWARD <= 1'b0;
			GO_BRAKE <= 1'b0;
			STOP_INSTANT <= 1'b0;
			DIR_FORWARD <= 1'b0;
			DATA_SELECT <= 3'h0;
		end else begin
			TOOL_LOCK_RELEASE <= st_tool;
			TORQUE_CAP_ENABLE <= st_tcap;
			MOTOR_FORCE_STOP <= !st_fault;
			MOTOR_RUN <= st_run;
			RUN_BACKWARD <= !mode_r && st_back;
			GO_BRAKE <= mode_r && st_back;
			STOP_INSTANT <= !mode_r && st_stop;
			DIR_FORWARD <= mode_r && st_stop;
			DATA_SELECT <= st_dsel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output slot select; echoes follow the input state in either mode
	generate
		for (genvar s = 0; s < 16; s++) begin : g_slot
			always_comb begin
				case (codes[s*8 +: 8])
					`RIO_FN_ALARM_CLEAR: rout_nxt[s] = st_aclr;
					`RIO_FN_NOTICE_CLEAR: rout_nxt[s] = st_nclr;
					`RIO_FN_TOOL_LOCK: rout_nxt[s] = st_tool;
					`RIO_FN_TORQUE_CAP: rout_nxt[s] = st_tcap;
					`RIO_FN_OUTSIDE_FAULT: rout_nxt[s] = st_fault;
					`RIO_FN_RUN_FORWARD: rout_nxt[s] = st_run;
					`RIO_FN_RUN_BACKWARD: rout_nxt[s] = st_back;
					`RIO_FN_STOP_MODE: rout_nxt[s] = st_stop;
					`RIO_FN_DSEL0: rout_nxt[s] = st_dsel[0];
					`RIO_FN_DSEL1: rout_nxt[s] = st_dsel[1];
					`RIO_FN_DSEL2: rout_nxt[s] = st_dsel[2];
					`RIO_FN_ALARM_OUT: rout_nxt[s] = ALARM_OUTPUT;
					`RIO_FN_MOVING: rout_nxt[s] = MOTOR_MOVING_FLAG;
					`RIO_FN_NOTICE: rout_nxt[s] = NOTICE_FLAG;
					`RIO_FN_BUSY: rout_nxt[s] = SYSTEM_BUSY_FLAG;
					`RIO_FN_TORQ_LIMITED: rout_nxt[s] = TORQUE_LIMITED_FLAG;
					`RIO_FN_SPEED_REACHED: rout_nxt[s] = SPEED_REACHED_FLAG;
					`RIO_FN_TURN_SENSE: rout_nxt[s] = TURN_SENSE_FLAG;
					`RIO_FN_MAIN_SUPPLY: rout_nxt[s] = MAIN_SUPPLY_FLAG;
					default: rout_nxt[s] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Slot bits registered so the host sees a clean word
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			REMOTE_OUT <= 16'h0;
		else
			REMOTE_OUT <= rout_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence s_aclr_rise;
		!st_aclr ##1 st_aclr;
	endsequence
	property p_aclr_once;
		s_aclr_rise |=> ALARM_CLEAR ##1 !ALARM_CLEAR;
	endproperty
	a_aclr_once: assert property (p_aclr_once) else $error("alarm clear pulse wrong");

	property p_aclr_held;
		st_aclr [*3] |=> !ALARM_CLEAR;
	endproperty
	a_aclr_held: assert property (p_aclr_held) else $error("alarm clear repeated");

	property p_nclr;
		$rose(st_nclr) |=> NOTICE_CLEAR;
	endproperty
	a_nclr: assert property (p_nclr) else $error("notice clear missed");

	property p_tool;
		st_tool |=> TOOL_LOCK_RELEASE;
	endproperty
	a_tool: assert property (p_tool) else $error("tool lock not released");

	property p_tcap;
		##1 TORQUE_CAP_ENABLE == $past(st_tcap);
	endproperty
	a_tcap: assert property (p_tcap) else $error("torque cap mismatch");

	property p_fault;
		$fell(st_fault) |=> EXT_STOP_ALARM && MOTOR_FORCE_STOP;
	endproperty
	a_fault: assert property (p_fault) else $error("outside stop alarm missed");

	property p_run;
		st_run |=> MOTOR_RUN;
	endproperty
	a_run: assert property (p_run) else $error("run not commanded");

	property p_back;
		mode_r && st_back |=> GO_BRAKE && !RUN_BACKWARD;
	endproperty
	a_back: assert property (p_back) else $error("code 59 meaning wrong");

	property p_stop;
		!mode_r && st_stop |=> STOP_INSTANT && !DIR_FORWARD;
	endproperty
	a_stop: assert property (p_stop) else $error("code 72 meaning wrong");

	property p_dsel;
		##1 DATA_SELECT == $past(st_dsel);
	endproperty
	a_dsel: assert property (p_dsel) else $error("data select wrong");

	// Refused write flags an error and leaves every stored code alone
	property p_refuse;
		wr_done && refuse |-> PSLVERR ##1 $stable(codes);
	endproperty
	a_refuse: assert property (p_refuse) else $error("fault code stored on remote slot");

	// Slot 11 holds code zero from reset, so this is exercised all run
	property p_zero;
		codes[11*8 +: 8] == `RIO_FN_UNUSED |=> !REMOTE_OUT[11];
	endproperty
	a_zero: assert property (p_zero) else $error("unused slot reports on");

endmodule // rio_signal_assign

/* test/rio_host_model.sv */
// APB host model standing in for the field bus controller
`timescale 1ns/1ps
module rio_host_model (
	input wire logic clk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	////////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////
	// One transfer; no fixed latency assumed, the bench timeout ends a hang
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		// Released lines show inverted values so stale data never matches
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // rio_host_model

/* test/rio_signal_assign_tb.sv */
// Self-checking bench of the remote I/O signal assignment block
`timescale 1ns/1ps
`include "rio_assign_cfg.svh"
module rio_signal_assign_tb;
	logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [4:0] DIRECT_IN;
	logic [7:0] sts;
	logic [15:0] REMOTE_OUT, r, eo;
	logic ALARM_CLEAR, NOTICE_CLEAR, TOOL_LOCK_RELEASE, TORQUE_CAP_ENABLE, EXT_STOP_ALARM;
	logic MOTOR_FORCE_STOP, MOTOR_RUN, RUN_BACKWARD, GO_BRAKE, STOP_INSTANT, DIR_FORWARD;
	logic [2:0] DATA_SELECT;
	logic [33:0] exp_q[$];
	logic [7:0] dflt[16] = '{8'h40, 8'h41, 8'h42, 8'h3a, 8'h3b, 8'h48, 8'h87, 8'h81,
		8'h88, 8'h94, 8'ha8, 8'h00, 8'h00, 8'h86, 8'h8d, 8'h8c};
	int fails = 0, n_tests = 0, cyc = 0, n_alm = 0, n_ntc = 0, n_ext = 0;
	logic m;

	////////////////////////////////////////////////////////////////////////////
	rio_signal_assign rio_signal_assign_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIRECT_IN(DIRECT_IN),
		.NOTICE_FLAG(sts[0]), .ALARM_OUTPUT(sts[1]), .SYSTEM_BUSY_FLAG(sts[2]),
		.TURN_SENSE_FLAG(sts[3]), .MAIN_SUPPLY_FLAG(sts[4]), .MOTOR_MOVING_FLAG(sts[5]),
		.SPEED_REACHED_FLAG(sts[6]), .TORQUE_LIMITED_FLAG(sts[7]), .REMOTE_OUT(REMOTE_OUT),
		.ALARM_CLEAR(ALARM_CLEAR), .NOTICE_CLEAR(NOTICE_CLEAR),
		.TOOL_LOCK_RELEASE(TOOL_LOCK_RELEASE), .TORQUE_CAP_ENABLE(TORQUE_CAP_ENABLE),
		.EXT_STOP_ALARM(EXT_STOP_ALARM), .MOTOR_FORCE_STOP(MOTOR_FORCE_STOP),
		.MOTOR_RUN(MOTOR_RUN), .RUN_BACKWARD(RUN_BACKWARD), .GO_BRAKE(GO_BRAKE),
		.STOP_INSTANT(STOP_INSTANT), .DIR_FORWARD(DIR_FORWARD), .DATA_SELECT(DATA_SELECT));
	rio_host_model host_i (.clk(MCLK), .pready(PREADY), .psel(PSEL), .penable(PENABLE),
		.pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));

	////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	// Pulse counters; a held level must not add more than one
	always @(posedge MCLK) begin
		if (ALARM_CLEAR === 1'b1) n_alm++;
		if (NOTICE_CLEAR === 1'b1) n_ntc++;
		if (EXT_STOP_ALARM === 1'b1) n_ext++;
	end
	// Hang guard, far above the expected run length
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			complete_run();
		end
	end
	// Completion monitor takes the oldest note per finished transfer
	always @(posedge MCLK) begin
		logic [33:0] e;
		if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("queue", 32'h1, 32'h0);
			end else begin
				e = exp_q.pop_front();
				if (e[33]) check("prdata", PRDATA, e[31:0]);
				check("pslverr", {31'h0, PSLVERR}, {31'h0, e[32]});
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d, logic err);
		exp_q.push_back({1'b0, err, 32'h0});
		host_i.xfer(1'b1, a, d);
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] d, logic err);
		exp_q.push_back({1'b1, err, d});
		host_i.xfer(1'b0, a, 32'h0);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic complete_run();
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		RST = 1'b1;
		DIRECT_IN = 5'h00;
		sts = 8'h00;
		void'($urandom(32'h2cc0));
		tick(10);
		RST <= 1'b0;
		// Reset codes of every output slot, then an unmapped place
		for (int s = 0; s < 16; s++) rd(12'(`RIO_OFS_OUT_CODE + 4 * s), {24'h0, dflt[s]}, 1'b0);
		rd(12'h100, 32'h0, 1'b1);
		wr(12'h104, 32'h1, 1'b1);
		check("tool_lock", {31'h0, TOOL_LOCK_RELEASE}, 32'h1);
		check("torque_cap", {31'h0, TORQUE_CAP_ENABLE}, 32'h1);
		check("force_stop", {31'h0, MOTOR_FORCE_STOP}, 32'h0);
		// Random remote inputs and status flags in both input modes
		for (int k = 0; k < 2; k++) begin
			m = k[0];
			wr(12'(`RIO_OFS_MODE), {31'h0, m}, 1'b0);
			repeat (4) begin
				r = 16'($urandom) & 16'h003f;
				sts <= 8'($urandom);
				wr(12'(`RIO_OFS_REMOTE_IN), {16'h0, r}, 1'b0);
				tick(6);
				eo = {sts[7:5], 2'b00, sts[4:0], r[5:0]};
				check("remote_out", {16'h0, REMOTE_OUT}, {16'h0, eo});
				check("data_sel", {29'h0, DATA_SELECT}, {29'h0, r[2:0]});
				check("run", {31'h0, MOTOR_RUN}, {31'h0, r[3]});
				check("backward", {31'h0, RUN_BACKWARD}, {31'h0, r[4] & ~m});
				check("go_brake", {31'h0, GO_BRAKE}, {31'h0, r[4] & m});
				check("stop_inst", {31'h0, STOP_INSTANT}, {31'h0, r[5] & ~m});
				check("dir_fwd", {31'h0, DIR_FORWARD}, {31'h0, r[5] & m});
			end
		end
		wr(12'(`RIO_OFS_MODE), 32'h0, 1'b0);
		// Alarm clear: one pulse per rising edge, none while held
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h80, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h80, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h00, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h80, 1'b0);
		tick(4);
		check("alarm_clear", n_alm, 32'd2);
		// Unused slot does nothing until it is given the notice clear code
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h40, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h00, 1'b0);
		tick(4);
		check("notice_unused", n_ntc, 32'd0);
		wr(12'(`RIO_OFS_IN_CODE + 24), 32'h0e, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h40, 1'b0);
		tick(4);
		check("notice_clear", n_ntc, 32'd1);
		// Outside fault code refused on a remote slot
		wr(12'(`RIO_OFS_IN_CODE + 40), 32'h19, 1'b1);
		rd(12'(`RIO_OFS_IN_CODE + 40), 32'h0, 1'b0);
		// Tool lock and torque cap follow their assigned terminals
		wr(12'(`RIO_OFS_IN_CODE + 32), 32'h10, 1'b0);
		wr(12'(`RIO_OFS_IN_CODE + 36), 32'h16, 1'b0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h0, 1'b0);
		tick(6);
		check("tool_off", {31'h0, TOOL_LOCK_RELEASE}, 32'h0);
		check("cap_off", {31'h0, TORQUE_CAP_ENABLE}, 32'h0);
		wr(12'(`RIO_OFS_REMOTE_IN), 32'h300, 1'b0);
		tick(6);
		check("tool_on", {31'h0, TOOL_LOCK_RELEASE}, 32'h1);
		check("cap_on", {31'h0, TORQUE_CAP_ENABLE}, 32'h1);
		// Several terminals: AND for tool lock, OR for run
		wr(12'(`RIO_OFS_DIR_CODE), 32'h10, 1'b0);
		wr(12'(`RIO_OFS_DIR_CODE + 8), 32'h3a, 1'b0);
		tick(6);
		check("tool_and", {31'h0, TOOL_LOCK_RELEASE}, 32'h0);
		DIRECT_IN <= 5'h05;
		tick(6);
		check("tool_and1", {31'h0, TOOL_LOCK_RELEASE}, 32'h1);
		check("run_or", {31'h0, MOTOR_RUN}, 32'h1);
		// Outside fault on a direct pin: alarm only when it turns off
		DIRECT_IN <= 5'h07;
		wr(12'(`RIO_OFS_DIR_CODE + 4), 32'h19, 1'b0);
		tick(6);
		check("ext_none", n_ext, 32'd0);
		DIRECT_IN <= 5'h05;
		tick(6);
		check("ext_alarm", n_ext, 32'd1);
		check("force_on", {31'h0, MOTOR_FORCE_STOP}, 32'h1);
		complete_run();
	end
endmodule // rio_signal_assign_tb
